/* File: bidir_port_d_with_bus_override_tb_top.sv */
// testbench: register and pin tests of the bidirectional port
`timescale 1ns/1ps
module bidir_port_d_with_bus_override_tb_top;
    import bpd_pkg::*;
    logic       clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic       bus_drive_i = 1'b0, host_read_i = 1'b0, host_write_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00, bus_addr_data_i = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] reg_rdata_o, pin_i, pin_o, pin_oe_o, pin_pullup_o, bus_data_o;
    logic [7:0] parallel_slave_data_o;
    logic       parallel_slave_strobe_o;
    logic [1:0] owner_o;
    int         failures = 0;
    int         check_count = 0;
    always #4 clk_i = ~clk_i;
    bpd_port dut (.*);
    bpd_pads pads (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(pin_i));
    // ====
    // tasks
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("reg_rdata_o", reg_rdata_o, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic end_sim;
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ====
    // tests
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1 chk("pin_oe_o", pin_oe_o, 8'h00);
        chk("pin_pullup_o", pin_pullup_o, 8'h00);
        rd(BPD_ADDR_DIR, BPD_DIR_RESET);
        @(posedge clk_i);
        {bus_drive_i, bus_addr_data_i} <= {1'b1, 8'h5a};
        wr(BPD_ADDR_DIR, 8'h00);
        wr(BPD_ADDR_PARCTL, 8'h10);
        wr(BPD_ADDR_LATCH, 8'h3c);
        settle;
        chk("owner_o", {6'h00, owner_o}, {6'h00, BPD_OWN_BUS});
        chk("pin_o", pin_o, 8'h5a);
        chk("pin_oe_o", pin_oe_o, 8'hff);
        @(posedge clk_i);
        {bus_drive_i, ext_en, ext_val} <= {1'b0, 8'hff, 8'hc3};
        settle;
        chk("bus_data_o", bus_data_o, 8'hc3);
        wr(BPD_ADDR_MEMCTL, 8'h80);
        @(posedge clk_i);
        {host_write_i, ext_val} <= {1'b1, 8'ha5};
        settle;
        chk("pin_oe_o", pin_oe_o, 8'h00);
        chk("parallel_slave_strobe_o", {7'h00, parallel_slave_strobe_o}, 8'h01);
        chk("owner_o", {6'h00, owner_o}, {6'h00, BPD_OWN_PSP});
        rd(BPD_ADDR_PSPIN, 8'ha5);
        @(posedge clk_i);
        {host_write_i, host_read_i, ext_en} <= {1'b0, 1'b1, 8'h00};
        settle;
        chk("pin_o", pin_o, 8'h3c);
        chk("pin_oe_o", pin_oe_o, 8'hff);
        chk("parallel_slave_strobe_o", {7'h00, parallel_slave_strobe_o}, 8'h00);
        @(posedge clk_i);
        {host_read_i, ext_en, ext_val} <= {1'b0, 8'h0f, 8'h0c};
        wr(BPD_ADDR_PARCTL, 8'h00);
        wr(BPD_ADDR_DIR, 8'h0f);
        wr(BPD_ADDR_PORT, 8'h96);
        settle;
        chk("pin_oe_o", pin_oe_o, 8'hf0);
        rd(BPD_ADDR_LATCH, 8'h96);
        rd(BPD_ADDR_PORT, 8'h9c);
        @(posedge clk_i);
        ext_en <= 8'h00;
        wr(BPD_ADDR_AUX, 8'h80);
        settle;
        chk("pin_pullup_o", pin_pullup_o, 8'h0f);
        rd(BPD_ADDR_PORT, 8'h9f);
        rd(3'h7, 8'h00);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(BPD_ADDR_AUX, BPD_AUX_RESET);
        rd(BPD_ADDR_DIR, BPD_DIR_RESET);
        end_sim;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        failures++;
        end_sim;
    end
endmodule

/* File: bpd_pads.sv */
// partner: pad levels from device drive, far side drive, pull-ups or drift
`timescale 1ns/1ps
module bpd_pads (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_o,
    input  wire logic [7:0] pin_pullup_o,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] pin_level_o
);
    logic [7:0] float_reg = 8'h00;
    always @(posedge clk_i) float_reg <= ~pin_level_o;
    assign pin_level_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
        | (~pin_oe_o & ~ext_en_i & (pin_pullup_o | float_reg));
endmodule

/* File: bpd_pkg.sv */
// package: register map, field positions and reset values of the bidirectional port block
// Overview of operation
// [R1] the block offers eight bidirectional pins, each backed by one direction bit and one latch bit.
// [R2] a direction bit of 0 drives the pin from its latch bit; a 1 makes it an input read back through the port register.
// [R3] every reset sets all direction bits so that all eight pins come up as inputs.
// [R4] each pin has a weak pull-up, and clearing bit 7 of the auxiliary port register switches all of them off.
// [R5] a pin set as output never has its pull-up on, whatever the shared enable says.
// [R6] reset clears the shared pull-up enable, so every pull-up is off after reset.
// [R7] port functions work only while bit 7 of the memory control register disables the memory bus.
// [R8] with the memory bus enabled the pins carry the low address/data byte and the direction bits are overridden.
// [R9] memory bus activity outranks both port and parallel slave use of the pins.
// [R10] the memory bus function exists only when the block is built for the large package.
// [R11] setting bit 4 of the parallel port control register makes the pins a parallel slave data port over the port I/O.
// [R12] in parallel slave mode a host read sees the latch on the pins, and a host write is taken in from the pins.
// [R13] writing the port register loads the latch; reading it gives pin levels, and reading the latch register gives the latch.
package bpd_pkg;
    localparam int unsigned BPD_WIDTH = 8;
    localparam logic [2:0] BPD_ADDR_PORT   = 3'h0;
    localparam logic [2:0] BPD_ADDR_LATCH  = 3'h1;
    localparam logic [2:0] BPD_ADDR_DIR    = 3'h2;
    localparam logic [2:0] BPD_ADDR_AUX    = 3'h3;
    localparam logic [2:0] BPD_ADDR_MEMCTL = 3'h4;
    localparam logic [2:0] BPD_ADDR_PARCTL = 3'h5;
    localparam logic [2:0] BPD_ADDR_PSPIN  = 3'h6;
    localparam int unsigned BPD_PULLUP_BIT  = 7;
    localparam int unsigned BPD_BUSDIS_BIT  = 7;
    localparam int unsigned BPD_PARALLEL_SLAVE_MODE_BIT = 4;
    localparam logic [7:0] BPD_DIR_RESET    = 8'hff;
    localparam logic [7:0] BPD_LATCH_RESET  = 8'h00;
    localparam logic [7:0] BPD_AUX_RESET    = 8'h00;
    localparam logic [7:0] BPD_MEMCTL_RESET = 8'h00;
    localparam logic [7:0] BPD_PARCTL_RESET = 8'h00;
    typedef enum logic [1:0] {
        BPD_OWN_PORT = 2'b00,
        BPD_OWN_PSP  = 2'b01,
        BPD_OWN_BUS  = 2'b11
    } bpd_owner_type;
endpackage

/* File: bpd_port.sv */
// module: eight-bit bidirectional port with memory bus and parallel slave override
`timescale 1ns/1ps
module bpd_port
    import bpd_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [2:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [7:0] pin_i,
    output logic      [7:0] pin_o,
    output logic      [7:0] pin_oe_o,
    output logic      [7:0] pin_pullup_o,
    input  wire logic [7:0] bus_addr_data_i,
    input  wire logic       bus_drive_i,
    output logic      [7:0] bus_data_o,
    input  wire logic       host_read_i,
    input  wire logic       host_write_i,
    output logic      [7:0] parallel_slave_data_o,
    output logic            parallel_slave_strobe_o,
    output logic      [1:0] owner_o
);
    // ======================================================================
    // registers
    logic [7:0] port_output_latch_reg;
    logic [7:0] port_direction_reg;
    logic [7:0] aux_port_and_pullup_ctrl_reg;
    logic [7:0] memory_control_reg;
    logic [7:0] parallel_port_control_reg;
    logic [7:0] parallel_slave_data_reg;
    logic [7:0] rdata_next;
    logic [7:0] pin_o_next;
    logic [7:0] pin_oe_next;
    logic [7:0] pullup_next;
    bpd_owner_type owner_next;

    // ======================================================================
    // decode
    wire sel_port   = (reg_addr_i == BPD_ADDR_PORT);
    wire sel_latch  = (reg_addr_i == BPD_ADDR_LATCH);
    wire sel_dir    = (reg_addr_i == BPD_ADDR_DIR);
    wire sel_aux    = (reg_addr_i == BPD_ADDR_AUX);
    wire sel_memctl = (reg_addr_i == BPD_ADDR_MEMCTL);
    wire sel_parctl = (reg_addr_i == BPD_ADDR_PARCTL);
    wire sel_pspin  = (reg_addr_i == BPD_ADDR_PSPIN);

    // memory bus exists only on the large package
    wire bus_enabled = LARGE_PACKAGE && !memory_control_reg[BPD_BUSDIS_BIT]; // [R10] [R7]
    wire psp_mode    = parallel_port_control_reg[BPD_PARALLEL_SLAVE_MODE_BIT];        // [R11]
    wire pullup_en   = aux_port_and_pullup_ctrl_reg[BPD_PULLUP_BIT];

    // ======================================================================
    // pin ownership and drive
    always_comb begin
        if (bus_enabled) begin
            owner_next = BPD_OWN_BUS; // [R9]
        end else if (psp_mode) begin
            owner_next = BPD_OWN_PSP; // [R11]
        end else begin
            owner_next = BPD_OWN_PORT;
        end
    end

    always_comb begin
        pin_o_next  = 8'h00;
        pin_oe_next = 8'h00;
        pullup_next = 8'h00;
        case (owner_next)
            BPD_OWN_BUS: begin
                // direction bits overridden, bus drives address/data
                pin_o_next  = bus_addr_data_i;             // [R8]
                pin_oe_next = {8{bus_drive_i}};            // [R8] [R9]
            end
            BPD_OWN_PSP: begin
                pin_o_next  = port_output_latch_reg;       // [R12]
                pin_oe_next = {8{host_read_i}};            // [R12]
            end
            default: begin
                pin_o_next  = port_output_latch_reg;       // [R2]
                pin_oe_next = ~port_direction_reg;         // [R2]
                pullup_next = port_direction_reg & {8{pullup_en}}; // [R4] [R5]
            end
        endcase
    end

    always_comb begin
        if (sel_port) begin
            rdata_next = pin_i;                            // [R13]
        end else if (sel_latch) begin
            rdata_next = port_output_latch_reg;            // [R13]
        end else if (sel_dir) begin
            rdata_next = port_direction_reg;
        end else if (sel_aux) begin
            rdata_next = aux_port_and_pullup_ctrl_reg;
        end else if (sel_memctl) begin
            rdata_next = memory_control_reg;
        end else if (sel_parctl) begin
            rdata_next = parallel_port_control_reg;
        end else if (sel_pspin) begin
            rdata_next = parallel_slave_data_reg;
        end else begin
            rdata_next = 8'h00;
        end
    end

    wire psp_capture = (owner_next == BPD_OWN_PSP) && host_write_i;

    // ======================================================================
    // state
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            port_output_latch_reg        <= BPD_LATCH_RESET;
            port_direction_reg           <= BPD_DIR_RESET;     // [R3]
            aux_port_and_pullup_ctrl_reg <= BPD_AUX_RESET;     // [R6]
            memory_control_reg           <= BPD_MEMCTL_RESET;
            parallel_port_control_reg    <= BPD_PARCTL_RESET;
        end else if (reg_wr_i) begin
            if (sel_port || sel_latch) begin
                port_output_latch_reg <= reg_wdata_i;          // [R1] [R13]
            end
            if (sel_dir) begin
                port_direction_reg <= reg_wdata_i;             // [R1] [R2]
            end
            if (sel_aux) begin
                aux_port_and_pullup_ctrl_reg <= reg_wdata_i;   // [R4]
            end
            if (sel_memctl) begin
                memory_control_reg <= reg_wdata_i;             // [R7]
            end
            if (sel_parctl) begin
                parallel_port_control_reg <= reg_wdata_i;      // [R11]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            parallel_slave_data_reg <= 8'h00;
            parallel_slave_strobe_o <= 1'b0;
        end else begin
            if (psp_capture) begin
                parallel_slave_data_reg <= pin_i;              // [R12]
            end
            parallel_slave_strobe_o <= psp_capture;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o  <= 8'h00;
            pin_o        <= 8'h00;
            pin_oe_o     <= 8'h00;                             // [R3]
            pin_pullup_o <= 8'h00;                             // [R6]
            bus_data_o   <= 8'h00;
            owner_o      <= BPD_OWN_PORT;
        end else begin
            reg_rdata_o  <= reg_rd_i ? rdata_next : 8'h00;
            pin_o        <= pin_o_next;
            pin_oe_o     <= pin_oe_next;
            pin_pullup_o <= pullup_next;
            bus_data_o   <= bus_enabled ? pin_i : 8'h00;       // [R9]
            owner_o      <= owner_next;
        end
    end

    assign parallel_slave_data_o = parallel_slave_data_reg;
endmodule

/* File: bpd_port_properties.sv */
// checker: pin and bus timing of the bidirectional port
`timescale 1ns/1ps
module bpd_port_properties
    import bpd_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic [7:0] pin_pullup_o,
    input wire logic [7:0] bus_addr_data_i,
    input wire logic       bus_drive_i,
    input wire logic [7:0] bus_data_o,
    input wire logic       host_read_i,
    input wire logic       host_write_i,
    input wire logic [7:0] parallel_slave_data_o,
    input wire logic [1:0] owner_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ====
    // assertions
    a_reset_idle: assert property (
        $rose(reset_n_i) |-> !pin_oe_o && !pin_pullup_o) else $error("pins busy after reset");
    a_pullup_output: assert property (
        (pin_pullup_o & pin_oe_o) == 8'h00) else $error("pull-up on output");
    a_pullup_port_only: assert property (
        owner_o != BPD_OWN_PORT |-> !pin_pullup_o) else $error("pull-up outside port mode");
    a_read_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
    a_bus_drive: assert property (
        owner_o == BPD_OWN_BUS && $past(bus_drive_i) |-> pin_oe_o == 8'hff
        && pin_o == $past(bus_addr_data_i)) else $error("bus byte not driven");
    a_bus_input: assert property (
        owner_o == BPD_OWN_BUS |-> bus_data_o == $past(pin_i)) else $error("bus input lost");
    a_psp_read: assert property (
        owner_o == BPD_OWN_PSP |-> pin_oe_o == {8{$past(host_read_i)}}) else $error("host read drive");
    a_psp_write: assert property (
        owner_o == BPD_OWN_PSP && $past(host_write_i) |-> parallel_slave_data_o == $past(pin_i))
        else $error("host write not taken");
    a_small_package: assert property (
        !LARGE_PACKAGE |-> owner_o != BPD_OWN_BUS) else $error("bus on small package");
    c_bus: cover property (owner_o == BPD_OWN_BUS && pin_oe_o == 8'hff);
    c_psp: cover property (owner_o == BPD_OWN_PSP && host_write_i);
    c_pullup: cover property (pin_pullup_o != 8'h00);
endmodule
bind bpd_port bpd_port_properties #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_props (.*);
